// >>> hdl/pwmoft_defs.svh
`ifndef PWMOFT_DEFS_SVH
`define PWMOFT_DEFS_SVH
// Block geometry: channels, complementary pairs, fault inputs, match triggers.
`define PWMOFT_NCH          8
`define PWMOFT_NPAIR        4
`define PWMOFT_NFLT         4
`define PWMOFT_NTRG         6
`define PWMOFT_FCNT_W       5
`define PWMOFT_AW           8
// Register byte offsets on the APB port.
`define PWMOFT_OFF_CTRL     8'h00
`define PWMOFT_OFF_MASK     8'h04
`define PWMOFT_OFF_POL      8'h08
`define PWMOFT_OFF_PRESET   8'h0C
`define PWMOFT_OFF_FCTL     8'h10
`define PWMOFT_OFF_FSTS     8'h14
`define PWMOFT_OFF_TRIG     8'h18
// Control register fields.
`define PWMOFT_CTRL_ENH     0
`define PWMOFT_CTRL_FM_LO   1
`define PWMOFT_CTRL_FM_HI   2
`define PWMOFT_CTRL_MSYNC   3
`define PWMOFT_CTRL_RTRIG   4
`define PWMOFT_CTRL_IRQEN   5
`define PWMOFT_CTRL_INIT    6
// Fault control register fields.
`define PWMOFT_FCTL_FEN_LO  0
`define PWMOFT_FCTL_FFE_LO  4
`define PWMOFT_FCTL_FVAL_LO 8
`define PWMOFT_FCTL_GATE_LO 16
// Fault status register fields.
`define PWMOFT_FSTS_FLG_LO  0
`define PWMOFT_FSTS_SUM     7
`define PWMOFT_FSTS_LVL     8
`define PWMOFT_FSTS_LVLS_LO 12
// Reset and idle values.
`define PWMOFT_RST_WORD     32'h0000_0000
`define PWMOFT_FCNT_MAX     5'h1F
`endif

// >>> hdl/pwmoft_pkg.sv
`include "pwmoft_defs.svh"
package pwmoft_pkg;
   // Fault control mode; with enhanced features on, any nonzero code turns fault control on.
   typedef enum logic [1:0] {
      fm_off   = 2'b00,
      fm_man_a = 2'b01,
      fm_man_b = 2'b10,
      fm_auto  = 2'b11
   } pwmoft_fmode_type;

   // State of one fault input: synchroniser, filter counter, accepted level.
   typedef struct packed {
      logic                      s1;
      logic                      s2;
      logic                      s3;
      logic [`PWMOFT_FCNT_W-1:0] cnt;
      logic                      level;
      logic                      level_d;
   } pwmoft_filt_state_type;

   // State of the output stage and its register file.
   typedef struct packed {
      logic                      enh;
      pwmoft_fmode_type          fmode;
      logic                      msync;
      logic                      rtrig_en;
      logic                      irq_en;
      logic [`PWMOFT_NCH-1:0]    mask_buf;
      logic [`PWMOFT_NCH-1:0]    mask;
      logic [`PWMOFT_NCH-1:0]    pol;
      logic [`PWMOFT_NCH-1:0]    preset;
      logic [`PWMOFT_NFLT-1:0]   fin_en;
      logic [`PWMOFT_NFLT-1:0]   ffilt_en;
      logic [3:0]                fval;
      logic [`PWMOFT_NPAIR-1:0]  pair_gate;
      logic [`PWMOFT_NTRG-1:0]   trig_sel;
      logic [`PWMOFT_NFLT-1:0]   fflag;
      logic                      clr_armed;
      logic [`PWMOFT_NPAIR-1:0]  pair_dis;
      logic                      lvl_or_d;
      logic                      init_hold;
      logic [`PWMOFT_NCH-1:0]    out;
      logic                      match_trig;
      logic                      reload_trig;
      logic [31:0]               rdata;
      logic                      err;
   } pwmoft_state_type;
endpackage

// >>> hdl/pwmoft_filt_if.sv
`timescale 1ns/10ps
`default_nettype none
// Link between the output stage and one fault input filter.
interface pwmoft_filt_if;
   logic       pin;
   logic       ce;
   logic       filter_on;
   logic [3:0] fval;
   logic       level;
   logic       rise;
   modport filter (input pin, ce, filter_on, fval, output level, rise);
   modport owner  (output pin, ce, filter_on, fval, input level, rise);
endinterface
`default_nettype wire

// >>> hdl/pwmoft_fault_filter.sv
`timescale 1ns/10ps
`default_nettype none
module pwmoft_fault_filter #(
   parameter int CNT_W = `PWMOFT_FCNT_W
) (
   input  wire logic           pclk,
   input  wire logic           presetn,
   pwmoft_filt_if.filter       f
);
   pwmoft_pkg::pwmoft_filt_state_type st;
   pwmoft_pkg::pwmoft_filt_state_type next_st;
   logic                              accept;

   // Accepting one count ahead puts the level 3 + value edges after the pin.
   assign accept = ({1'b0, st.cnt} + 6'h02) > {2'b00, f.fval};

   // Three-stage synchroniser, then a restartable stability counter.
   always_comb begin
      next_st    = st;
      next_st.s1 = f.pin;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (st.s2 != st.s3) begin
         next_st.cnt = '0;
      end else if (st.cnt != CNT_W'(`PWMOFT_FCNT_MAX)) begin
         next_st.cnt = st.cnt + CNT_W'(1);
      end
      if (!f.filter_on) begin
         next_st.level = st.s2;
      end else if ((st.s2 == st.s3) && (st.s2 != st.level) && accept) begin
         next_st.level = st.s2;
      end
      next_st.level_d = st.level;
   end

   // Bypass taps the synchroniser directly; with the filter on, a short glitch never moves the accepted level.
   assign f.level = f.filter_on ? st.level : st.s2;
   assign f.rise  = f.filter_on ? (st.level & ~st.level_d) : (st.s2 & ~st.s3);

   // Single state register, frozen while the clock enable is low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else if (f.ce) begin
         st <= next_st;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/pwmoft_output_stage.sv
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Mask writes land in a buffer; active mask loads on the selected sync event.
// - A masked channel drives its inactive level set by its polarity bit.
// - Fault control is on only with enhanced features and nonzero fault mode.
// - Four fault inputs, each with enable and filter enable, one shared filter value.
// - Each fault input is synchronised to the system clock before filtering.
// - A 5-bit counter restarts on change; level accepted once count exceeds value.
// - Returning early resets the counter; short pulses never reach the edge detector.
// - Bypassed filter delays two edges; the flag sets on the third edge.
// - Filtered input delays three plus value edges; flag sets four plus value.
// - Enabled input rising edge sets its flag; summary flag is their OR.
// - Fault edge with gated pair forces both pair outputs to polarity values.
// - Fault interrupt follows summary flag AND interrupt enable.
// - Summary flag clears only by read as one then write of zero.
// - Auto mode re-enables outputs once fault level is low at cycle start.
// - Manual modes re-enable outputs once flag is clear at cycle start.
// - Enhanced polarity bit one inverts the channel output, zero passes it.
// - Writing initialize drives preset values, above every other output feature.
// - Selected channel matches pulse the match trigger output.
// - Counter reload pulses the reload trigger when enabled.
// - Without mask sync, buffer writes reach the active mask next edge.
module pwmoft_output_stage (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    pclken,
   input  wire logic [`PWMOFT_AW-1:0]   paddr,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [31:0]             pwdata,
   output logic [31:0]                  prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic [`PWMOFT_NFLT-1:0] fault_pin,
   input  wire logic [`PWMOFT_NCH-1:0]  chan_pwm,
   input  wire logic [`PWMOFT_NTRG-1:0] chan_match,
   input  wire logic                    counter_reload,
   input  wire logic                    mask_sync_event,
   output logic [`PWMOFT_NCH-1:0]       chan_out,
   output logic                         match_trigger,
   output logic                         reload_trigger,
   output logic                         fault_irq,
   output logic                         fault_level_status
);
   pwmoft_pkg::pwmoft_state_type st;
   pwmoft_pkg::pwmoft_state_type next_st;
   logic [`PWMOFT_NFLT-1:0]      flt_level;
   logic [`PWMOFT_NFLT-1:0]      flt_rise;
   logic                         fault_active;
   logic                         fault_summary_flag;
   logic                         lvl_or;
   logic                         fault_edge;
   logic                         apb_setup;
   logic                         apb_done;
   logic                         wr_done;
   logic                         rd_done;

   pwmoft_filt_if fif [`PWMOFT_NFLT] ();

   // Address decode shared by the read mux, the error answer and the write strobes.
   function automatic logic reg_hit(input logic [`PWMOFT_AW-1:0] addr,
                                    input logic [`PWMOFT_AW-1:0] off);
      reg_hit = (addr == off);
   endfunction

   function automatic logic reg_mapped(input logic [`PWMOFT_AW-1:0] addr);
      reg_mapped = reg_hit(addr, `PWMOFT_OFF_CTRL) || reg_hit(addr, `PWMOFT_OFF_MASK) ||
                   reg_hit(addr, `PWMOFT_OFF_POL) || reg_hit(addr, `PWMOFT_OFF_PRESET) ||
                   reg_hit(addr, `PWMOFT_OFF_FCTL) || reg_hit(addr, `PWMOFT_OFF_FSTS) ||
                   reg_hit(addr, `PWMOFT_OFF_TRIG);
   endfunction

   // One filter per fault input; each sees the shared filter value.
   generate
      for (genvar i = 0; i < `PWMOFT_NFLT; i++) begin : g_flt
         assign fif[i].pin       = fault_pin[i];
         assign fif[i].ce        = pclken;
         assign fif[i].fval      = st.fval;
         assign fif[i].filter_on = st.fin_en[i] & st.ffilt_en[i] & (st.fval != 4'h0);
         assign flt_level[i]     = fif[i].level;
         assign flt_rise[i]      = fif[i].rise;
         pwmoft_fault_filter #(
            .CNT_W (`PWMOFT_FCNT_W)
         ) u_filt (
            .pclk    (pclk),
            .presetn (presetn),
            .f       (fif[i])
         );
      end
   endgenerate

   // Fault control qualifiers and the edge on the OR of enabled inputs.
   assign fault_active       = st.enh && (st.fmode != pwmoft_pkg::fm_off);
   assign fault_summary_flag = |st.fflag;
   assign lvl_or             = |(flt_level & st.fin_en);
   assign fault_edge         = lvl_or & ~st.lvl_or_d;

   // APB phases; a stalled clock enable stretches the access phase.
   assign apb_setup = psel & ~penable;
   assign apb_done  = psel & penable & pclken;
   assign wr_done   = apb_done & pwrite & ~st.err;
   assign rd_done   = apb_done & ~pwrite & ~st.err;

   // Next-state logic for the whole output stage.
   always_comb begin
      logic x;
      x       = 1'b0;
      next_st = st;

      // Read data and the error answer are captured during the setup phase.
      if (apb_setup) begin
         next_st.err   = ~reg_mapped(paddr);
         next_st.rdata = `PWMOFT_RST_WORD;
         if (reg_hit(paddr, `PWMOFT_OFF_CTRL)) begin
            next_st.rdata[`PWMOFT_CTRL_ENH]                     = st.enh;
            next_st.rdata[`PWMOFT_CTRL_FM_HI:`PWMOFT_CTRL_FM_LO] = st.fmode;
            next_st.rdata[`PWMOFT_CTRL_MSYNC]                   = st.msync;
            next_st.rdata[`PWMOFT_CTRL_RTRIG]                   = st.rtrig_en;
            next_st.rdata[`PWMOFT_CTRL_IRQEN]                   = st.irq_en;
         end else if (reg_hit(paddr, `PWMOFT_OFF_MASK)) begin
            next_st.rdata[`PWMOFT_NCH-1:0] = st.mask;
         end else if (reg_hit(paddr, `PWMOFT_OFF_POL)) begin
            next_st.rdata[`PWMOFT_NCH-1:0] = st.pol;
         end else if (reg_hit(paddr, `PWMOFT_OFF_PRESET)) begin
            next_st.rdata[`PWMOFT_NCH-1:0] = st.preset;
         end else if (reg_hit(paddr, `PWMOFT_OFF_FCTL)) begin
            next_st.rdata[`PWMOFT_FCTL_FEN_LO +: `PWMOFT_NFLT]   = st.fin_en;
            next_st.rdata[`PWMOFT_FCTL_FFE_LO +: `PWMOFT_NFLT]   = st.ffilt_en;
            next_st.rdata[`PWMOFT_FCTL_FVAL_LO +: 4]             = st.fval;
            next_st.rdata[`PWMOFT_FCTL_GATE_LO +: `PWMOFT_NPAIR] = st.pair_gate;
         end else if (reg_hit(paddr, `PWMOFT_OFF_FSTS)) begin
            next_st.rdata[`PWMOFT_FSTS_FLG_LO +: `PWMOFT_NFLT]  = st.fflag;
            next_st.rdata[`PWMOFT_FSTS_SUM]                     = fault_summary_flag;
            next_st.rdata[`PWMOFT_FSTS_LVL]                     = lvl_or;
            next_st.rdata[`PWMOFT_FSTS_LVLS_LO +: `PWMOFT_NFLT] = flt_level;
         end else if (reg_hit(paddr, `PWMOFT_OFF_TRIG)) begin
            next_st.rdata[`PWMOFT_NTRG-1:0] = st.trig_sel;
         end
      end

      // A new PWM cycle ends any initialisation hold.
      if (counter_reload) begin
         next_st.init_hold = 1'b0;
      end

      // Register writes take effect on the completing access edge.
      if (wr_done) begin
         if (reg_hit(paddr, `PWMOFT_OFF_CTRL)) begin
            next_st.enh      = pwdata[`PWMOFT_CTRL_ENH];
            next_st.fmode    =
               pwmoft_pkg::pwmoft_fmode_type'(pwdata[`PWMOFT_CTRL_FM_HI:`PWMOFT_CTRL_FM_LO]);
            next_st.msync    = pwdata[`PWMOFT_CTRL_MSYNC];
            next_st.rtrig_en = pwdata[`PWMOFT_CTRL_RTRIG];
            next_st.irq_en   = pwdata[`PWMOFT_CTRL_IRQEN];
            if (pwdata[`PWMOFT_CTRL_INIT] && pwdata[`PWMOFT_CTRL_ENH]) begin
               next_st.init_hold = 1'b1;
            end
         end else if (reg_hit(paddr, `PWMOFT_OFF_MASK)) begin
            next_st.mask_buf = pwdata[`PWMOFT_NCH-1:0];
         end else if (reg_hit(paddr, `PWMOFT_OFF_POL)) begin
            next_st.pol = pwdata[`PWMOFT_NCH-1:0];
         end else if (reg_hit(paddr, `PWMOFT_OFF_PRESET)) begin
            next_st.preset = pwdata[`PWMOFT_NCH-1:0];
         end else if (reg_hit(paddr, `PWMOFT_OFF_FCTL)) begin
            next_st.fin_en    = pwdata[`PWMOFT_FCTL_FEN_LO +: `PWMOFT_NFLT];
            next_st.ffilt_en  = pwdata[`PWMOFT_FCTL_FFE_LO +: `PWMOFT_NFLT];
            next_st.fval      = pwdata[`PWMOFT_FCTL_FVAL_LO +: 4];
            next_st.pair_gate = pwdata[`PWMOFT_FCTL_GATE_LO +: `PWMOFT_NPAIR];
         end else if (reg_hit(paddr, `PWMOFT_OFF_FSTS)) begin
            // Only a zero write after an armed read clears; any write disarms.
            if (st.clr_armed && !pwdata[`PWMOFT_FSTS_SUM]) begin
               next_st.fflag = '0;
            end
            next_st.clr_armed = 1'b0;
         end else if (reg_hit(paddr, `PWMOFT_OFF_TRIG)) begin
            next_st.trig_sel = pwdata[`PWMOFT_NTRG-1:0];
         end
      end

      // Reading the status with the summary flag set arms the clear.
      if (rd_done && reg_hit(paddr, `PWMOFT_OFF_FSTS)) begin
         next_st.clr_armed = fault_summary_flag;
      end

      // Active mask follows the buffer at once or waits for the sync event.
      if (!st.msync) begin
         next_st.mask = st.mask_buf;
      end else if (mask_sync_event) begin
         next_st.mask = st.mask_buf;
      end

      // Flags are set after the clear above, so a coincident event is kept.
      for (int i = 0; i < `PWMOFT_NFLT; i++) begin
         if (fault_active && st.fin_en[i] && flt_rise[i]) begin
            next_st.fflag[i] = 1'b1;
         end
      end
      next_st.lvl_or_d = lvl_or;

      // Pair recovery at a cycle start, then a fresh fault edge wins over it.
      for (int p = 0; p < `PWMOFT_NPAIR; p++) begin
         if (!fault_active) begin
            next_st.pair_dis[p] = 1'b0;
         end else if (counter_reload) begin
            if (st.fmode == pwmoft_pkg::fm_auto) begin
               if (!lvl_or) begin
                  next_st.pair_dis[p] = 1'b0;
               end
            end else if (!fault_summary_flag) begin
               next_st.pair_dis[p] = 1'b0;
            end
         end
         if (fault_active && fault_edge && st.pair_gate[p]) begin
            next_st.pair_dis[p] = 1'b1;
         end
      end

      // Per channel: mask, fault, polarity, then initialisation on top.
      for (int c = 0; c < `PWMOFT_NCH; c++) begin
         x = chan_pwm[c];
         if (st.mask[c]) begin
            x = 1'b0;
         end
         if (st.pair_dis[c / 2]) begin
            x = 1'b0;
         end
         if (st.enh) begin
            x = x ^ st.pol[c];
         end
         if (st.enh && st.init_hold) begin
            x = st.preset[c];
         end
         next_st.out[c] = x;
      end

      // Trigger pulses last one cycle per source event.
      next_st.match_trig  = st.enh & |(chan_match & st.trig_sel);
      next_st.reload_trig = st.enh & st.rtrig_en & counter_reload;
   end

   // Single state register; everything holds while the clock enable is low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else if (pclken) begin
         st <= next_st;
      end
   end

   // Zero-wait slave; pready drops only while the clock enable freezes the block.
   assign pready  = pclken;
   assign pslverr = psel & penable & st.err;
   assign prdata  = st.rdata;

   // Outputs come straight from the state register, except the interrupt level and the fault level status.
   assign chan_out           = st.out;
   assign match_trigger      = st.match_trig;
   assign reload_trigger     = st.reload_trig;
   assign fault_irq          = fault_summary_flag & st.irq_en;
   assign fault_level_status = lvl_or;
endmodule
`default_nettype wire

// >>> verification/pwmoft_output_stage_props.sv
`timescale 1ns/10ps
`default_nettype none
// Checks on the output stage ports.
module pwmoft_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        pclken,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [3:0]  fault_pin,
   input wire logic [7:0]  chan_pwm,
   input wire logic [5:0]  chan_match,
   input wire logic        counter_reload,
   input wire logic        mask_sync_event,
   input wire logic [7:0]  chan_out,
   input wire logic        match_trigger,
   input wire logic        reload_trigger,
   input wire logic        fault_irq,
   input wire logic        fault_level_status
);
   logic acc;
   logic clr_wr;
   // Only control or status writes may drop the interrupt.
   assign acc    = psel && penable;
   assign clr_wr = acc && pwrite && (paddr == 8'h00 || paddr == 8'h14);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_follow: assert property (pready == pclken)
      else $error("Ready off enable.");
   chk_unmapped_err: assert property (acc && !pwrite && paddr > 8'h18 |->
      pslverr && prdata == 32'h0000_0000) else $error("Unmapped read accepted.");
   chk_mapped_ok: assert property (acc && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("Mapped access refused.");
   chk_reset_quiet: assert property ($rose(presetn) |-> chan_out == 8'h00 && !fault_irq
      && !match_trigger && !reload_trigger && prdata == 32'h0000_0000)
      else $error("Noisy after reset.");
   chk_match_cause: assert property (match_trigger |-> $past(|chan_match))
      else $error("Stray match trigger.");
   chk_reload_cause: assert property (reload_trigger |-> $past(counter_reload))
      else $error("Stray reload trigger.");
   chk_reload_once: assert property (reload_trigger && !counter_reload |=> !reload_trigger)
      else $error("Long reload trigger.");
   chk_irq_hold: assert property (fault_irq && !clr_wr |=> fault_irq)
      else $error("Interrupt dropped.");
   chk_level_cause: assert property ($rose(fault_level_status) |->
      $past(|fault_pin) && $past(|fault_pin, 2)) else $error("Fault level rose too early.");
   // Scenarios to see once.
   cov_fault_irq: cover property ($rose(fault_irq));
   cov_match: cover property (match_trigger);
   cov_refused: cover property (acc && pslverr);
endmodule
`default_nettype wire

// >>> verification/pwmoft_partner.sv
`timescale 1ns/10ps
`default_nettype none
// Far side: a stoppable counter engine and the raw fault sources.
module pwmoft_partner #(
   parameter int PER = 16
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       run,
   input  wire logic [3:0] fault_req,
   output logic [3:0]      fault_pin,
   output logic [5:0]      chan_match,
   output logic            counter_reload
);
   logic [4:0] cnt;
   // The count only moves while run is high, so initialize meets a stopped counter.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 5'h00;
      end else if (run) begin
         cnt <= (cnt == 5'(PER - 1)) ? 5'h00 : cnt + 5'h01;
      end
   end
   // Reload marks the cycle that loads the start value; channel j matches at j+1.
   always_comb begin
      counter_reload = run && (cnt == 5'(PER - 1));
      for (int j = 0; j < 6; j++) begin
         chan_match[j] = run && (cnt == 5'(j + 1));
      end
   end
   // Fault sources drive the pins directly.
   assign fault_pin = fault_req;
endmodule
`default_nettype wire

// >>> verification/test_pwm_output_fault_trigger.sv
`timescale 1ns/10ps
`default_nettype none
module test_pwm_output_fault_trigger;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        pclken = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0, mask_sync_event = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic [3:0]  fault_req = 4'h0;
   logic [3:0]  fault_pin;
   logic [7:0]  chan_pwm = 8'h0F;
   logic [5:0]  chan_match;
   logic [7:0]  chan_out;
   logic        pready, pslverr, counter_reload, match_trigger, reload_trigger, last_err;
   logic        fault_irq, fault_level_status;
   int          bad_count = 0;
   int          check_count = 0;
   int          mt_n = 0, rt_n = 0;
   // Clock at 50 MHz.
   always #10 pclk = ~pclk;
   // Trigger pulses tallied per edge.
   always @(posedge pclk) begin
      mt_n += match_trigger;
      rt_n += reload_trigger;
   end
   pwmoft_output_stage dut (
      .pclk, .presetn, .pclken, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .fault_pin, .chan_pwm, .chan_match, .counter_reload, .mask_sync_event,
      .chan_out, .match_trigger, .reload_trigger, .fault_irq, .fault_level_status);
   pwmoft_partner #(.PER(16)) u_far (
      .pclk, .presetn, .run, .fault_req, .fault_pin, .chan_match, .counter_reload);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer, held until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 40) begin
         bad_count++;
      end
      r        = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0000_0000, r);
      check(r, e);
   endtask
   // Outputs are read mid-cycle, clear of edge updates.
   task automatic after(input int k);
      repeat (k) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic out_is(input int k, input logic [7:0] e);
      after(k);
      check(32'(chan_out), 32'(e));
   endtask
   task automatic sig_is(input int k, input logic irq, input logic e);
      after(k);
      check(32'(irq ? fault_irq : fault_level_status), 32'(e));
   endtask
   task automatic count_run(input int em, input int er);
      @(posedge pclk);
      mt_n = 0;
      rt_n = 0;
      run <= 1'b1;
      repeat (64) @(posedge pclk);
      run <= 1'b0;
      repeat (4) @(posedge pclk);
      check(32'(mt_n), 32'(em));
      check(32'(rt_n), 32'(er));
   endtask
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      // Registers reset clear; unmapped reads are refused.
      for (int i = 0; i < 7; i++) begin
         rd(8'(4 * i), 32'h0000_0000);
      end
      rd(8'h20, 32'h0000_0000);
      check(32'(last_err), 32'h0000_0001);
      // Polarity acts only once enhanced features are on.
      wr(8'h08, 32'h0000_0033);
      out_is(2, 8'h0F);
      wr(8'h00, 32'h0000_0001);
      out_is(2, 8'h3C);
      // Without sync the mask lands two edges after the write.
      wr(8'h04, 32'h0000_0003);
      out_is(1, 8'h3C);
      out_is(1, 8'h3F);
      // With sync selected the buffer waits for the event.
      wr(8'h00, 32'h0000_0009);
      wr(8'h04, 32'h0000_000C);
      rd(8'h04, 32'h0000_0003);
      out_is(4, 8'h3F);
      @(posedge pclk);
      mask_sync_event <= 1'b1;
      @(posedge pclk);
      mask_sync_event <= 1'b0;
      out_is(3, 8'h30);
      rd(8'h04, 32'h0000_000C);
      wr(8'h00, 32'h0000_0001);
      wr(8'h04, 32'h0000_0000);
      // Unfiltered fault in auto mode: level after two edges, flag on the third.
      wr(8'h10, 32'h0001_0001);
      wr(8'h00, 32'h0000_0027);
      @(posedge pclk);
      fault_req <= 4'h1;
      sig_is(1, 1'b0, 1'b0);
      sig_is(1, 1'b0, 1'b1);
      check(32'(fault_irq), 32'h0000_0000);
      sig_is(1, 1'b1, 1'b1);
      out_is(2, 8'h3F);
      rd(8'h14, 32'h0000_1181);
      run <= 1'b1;
      out_is(20, 8'h3F);
      fault_req <= 4'h0;
      out_is(24, 8'h3C);
      run <= 1'b0;
      // A write of one after the read disarms, so the zero write after it keeps the flag.
      wr(8'h14, 32'h0000_0080);
      wr(8'h14, 32'h0000_0000);
      sig_is(1, 1'b1, 1'b1);
      rd(8'h14, 32'h0000_0081);
      wr(8'h14, 32'h0000_0000);
      sig_is(1, 1'b1, 1'b0);
      // Manual mode needs the flag cleared before the new cycle.
      wr(8'h00, 32'h0000_0003);
      fault_req <= 4'h1;
      out_is(8, 8'h3F);
      fault_req <= 4'h0;
      run <= 1'b1;
      out_is(24, 8'h3F);
      run <= 1'b0;
      rd(8'h14, 32'h0000_0081);
      wr(8'h14, 32'h0000_0000);
      out_is(4, 8'h3F);
      run <= 1'b1;
      out_is(20, 8'h3C);
      run <= 1'b0;
      // With fault mode zero a fault neither flags nor disables.
      wr(8'h00, 32'h0000_0001);
      fault_req <= 4'h1;
      out_is(8, 8'h3C);
      rd(8'h14, 32'h0000_1100);
      fault_req <= 4'h0;
      // Filter value three: a two-cycle pulse drops, a long one lands late.
      wr(8'h00, 32'h0000_0023);
      wr(8'h10, 32'h0000_0311);
      fault_req <= 4'h1;
      repeat (2) @(posedge pclk);
      fault_req <= 4'h0;
      for (int i = 0; i < 12; i++) begin
         sig_is(1, 1'b0, 1'b0);
      end
      @(posedge pclk);
      fault_req <= 4'h1;
      sig_is(5, 1'b0, 1'b0);
      sig_is(1, 1'b0, 1'b1);
      check(32'(fault_irq), 32'h0000_0000);
      sig_is(1, 1'b1, 1'b1);
      fault_req <= 4'h0;
      sig_is(12, 1'b0, 1'b0);
      rd(8'h14, 32'h0000_0081);
      wr(8'h14, 32'h0000_0000);
      // Initialize overrides the mask on a stopped counter.
      wr(8'h10, 32'h0000_0000);
      wr(8'h0C, 32'h0000_005A);
      wr(8'h04, 32'h0000_00FF);
      out_is(2, 8'h33);
      wr(8'h00, 32'h0000_0041);
      out_is(2, 8'h5A);
      rd(8'h00, 32'h0000_0001);
      run <= 1'b1;
      out_is(20, 8'h33);
      run <= 1'b0;
      wr(8'h04, 32'h0000_0000);
      // Two selected channels pulse twice a period.
      wr(8'h18, 32'h0000_0005);
      wr(8'h00, 32'h0000_0011);
      count_run(8, 4);
      wr(8'h00, 32'h0000_0010);
      count_run(0, 0);
      print_verdict();
   end
   // Watchdog, far beyond the test length.
   initial begin
      #400000;
      bad_count++;
      print_verdict();
   end
endmodule
bind pwmoft_output_stage pwmoft_props u_props (
   .pclk, .presetn, .pclken, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
   .pslverr, .fault_pin, .chan_pwm, .chan_match, .counter_reload, .mask_sync_event,
   .chan_out, .match_trigger, .reload_trigger, .fault_irq, .fault_level_status);
`default_nettype wire
